// *** dv/host_model.sv ***
// Host serial master model issuing single-cycle register requests
`timescale 1ns/1ns
module host_model
    import isr_test_pkg::*;
(
    input wire logic clock_i,
    output reg_req_t req_o,
    output logic transfer_active_o
);
    initial begin
        req_o = '0;
        transfer_active_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Request held from one falling edge to the next, so one rising edge takes it
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock_i);
        req_o = '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(negedge clock_i);
        // Released bus shows inverted content, not a stale copy
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    task automatic set_busy(input logic b);
        transfer_active_o = b;
    endtask
endmodule

// *** dv/interrupt_status_and_test_control_tb.sv ***
// Testbench for the interrupt status and test control registers
`timescale 1ns/1ns
module interrupt_status_and_test_control_tb;
    import isr_test_pkg::*;
    logic clock_i = 1'b0;
    logic soft_reset_request_i = 1'b1;
    logic ce_i = 1'b1;
    logic [NUM_SRC-1:0] src = '0;
    reg_req_t req;
    logic busy;
    logic [7:0] rd_data;
    logic rd_hit, int_n, ack, sr;
    logic [7:0] ccode;
    bypass_t byp;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] rv;
    logic rh;

    always #20 clock_i = ~clock_i;

    host_model host (.clock_i(clock_i), .req_o(req), .transfer_active_o(busy));

    interrupt_status_and_test_control uut (.clock_i(clock_i), .soft_reset_request_i(soft_reset_request_i), .ce_i(ce_i), .req_i(req),
        .transfer_active_i(busy), .src_active_i(src), .rd_data_o(rd_data), .rd_hit_o(rd_hit),
        .int_n_o(int_n), .clear_ack_o(ack), .clear_code_o(ccode), .soft_reset_o(sr), .bypass_o(byp));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask

    // Read data stands one cycle only, so it is taken right at the release
    task automatic rd(input logic [7:0] a);
        host.access(1'b0, a, 8'h00);
        rv = rd_data;
        rh = rd_hit;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clock_i);
        soft_reset_request_i = 1'b0;
        chk("int_n", 8'h01, {7'h0, int_n});
        rd(ADDR_INT_STATUS);
        chk("status", STATUS_RESET, rv);
        chk("status hit", 8'h01, {7'h0, rh});
        rd(ADDR_TEST_CTRL);
        chk("test reg", 8'h00, rv);
        chk("bypass", 8'h00, {5'h0, byp});
        wr(ADDR_TEST_CTRL, 8'h04);
        chk("fan bypass", 8'h04, {5'h0, byp});
        wr(ADDR_TEST_CTRL, 8'h02);
        chk("flash bypass", 8'h02, {5'h0, byp});
        wr(ADDR_TEST_CTRL, 8'h01);
        chk("soft reset", 8'h00, {7'h0, sr});
        rd(ADDR_TEST_CTRL);
        chk("test reg", 8'h01, rv);
        rd(8'hFD);
        chk("unmapped data", 8'h00, rv);
        chk("unmapped hit", 8'h00, {7'h0, rh});
        // Frozen clock enable must swallow the write
        ce_i = 1'b0;
        wr(ADDR_TEST_CTRL, 8'h04);
        ce_i = 1'b1;
        chk("bypass frozen", 8'h01, {5'h0, byp});
        // Test bits back to normal before the functional scenarios
        wr(ADDR_TEST_CTRL, 8'h00);
        chk("bypass", 8'h00, {5'h0, byp});
        // All sources at once; drained strictly in code order
        src = '1;
        for (int i = 0; i < NUM_SRC; i++) begin
            repeat (3) @(negedge clock_i);
            chk("int_n", 8'h00, {7'h0, int_n});
            rd(ADDR_INT_STATUS);
            chk("status", SRC_CODE[i], rv);
            wr(ADDR_INT_STATUS, 8'h5A);
            chk("int_n", 8'h00, {7'h0, int_n});
            wr(ADDR_INT_STATUS, CLEAR_CODE);
            chk("int_n", 8'h01, {7'h0, int_n});
            chk("ack", 8'h01, {7'h0, ack});
            chk("clear code", SRC_CODE[i], ccode);
            src[i] = 1'b0;
        end
        repeat (3) @(negedge clock_i);
        chk("int_n", 8'h01, {7'h0, int_n});
        rd(ADDR_INT_STATUS);
        chk("status", STATUS_RESET, rv);
        // Clear with nothing active is refused
        wr(ADDR_INT_STATUS, CLEAR_CODE);
        chk("ack", 8'h00, {7'h0, ack});
        // Live interrupt must be dropped by the soft reset
        src[7] = 1'b1;
        repeat (3) @(negedge clock_i);
        chk("int_n", 8'h00, {7'h0, int_n});
        // Soft reset held off while a transfer is running
        host.set_busy(1'b1);
        wr(ADDR_TEST_CTRL, 8'h86);
        rd(ADDR_TEST_CTRL);
        chk("pending", 8'h86, rv);
        repeat (5) @(negedge clock_i);
        chk("soft reset", 8'h00, {7'h0, sr});
        host.set_busy(1'b0);
        for (int k = 0; k < 5 && sr !== 1'b1; k++) @(negedge clock_i);
        chk("soft reset", 8'h01, {7'h0, sr});
        chk("bypass", 8'h00, {5'h0, byp});
        chk("int_n", 8'h01, {7'h0, int_n});
        chk("clear code", STATUS_RESET, ccode);
        src = '0;
        rd(ADDR_TEST_CTRL);
        chk("test reg", 8'h00, rv);
        rd(ADDR_INT_STATUS);
        chk("status", STATUS_RESET, rv);
        summarize();
    end

    // Whole run is about 120 cycles; this bound only catches a hang
    initial begin
        #40000;
        failures++;
        summarize();
    end
endmodule

// *** rtl/interrupt_status_and_test_control.sv ***
// Interrupt source status register and test / soft reset register
`timescale 1ns/1ns
// Operation
// - Enabled sources from bypass, fan, bit and timer registers merge into one status.
// - Status field shows the address of the active source's enabling register.
// - With several sources active, the lowest address code is reported first.
// - Host writes FFh to status to clear; interrupt pin then goes inactive.
// - After clear, a remaining source is loaded and the pin asserts again.
// - Soft reset request waits until the current serial transfer has ended.
// - Soft reset returns pins, control registers, dividers and slave machine to reset.
// - Soft reset bit clears itself; writing zero to it does nothing.
// - Fan bypass bit skips the fan divider, counters run 500 times faster.
// - Flash bypass bit skips the flash divider, rates 125,000 times faster.
// - Both divider bypass bits are cleared at power-on and reset.
// - Filter bypass bit removes glitch filters on serial clock and data.
// - Filter bypass bit is cleared at power-on and reset.
module interrupt_status_and_test_control
    import isr_test_pkg::*;
(
    input wire logic clock_i,
    input wire logic soft_reset_request_i,
    input wire logic ce_i,
    input wire reg_req_t req_i,
    input wire logic transfer_active_i,
    input wire logic [NUM_SRC-1:0] src_active_i,
    output logic [7:0] rd_data_o,
    output logic rd_hit_o,
    output logic int_n_o,
    output logic clear_ack_o,
    output logic [7:0] clear_code_o,
    output logic soft_reset_o,
    output bypass_t bypass_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    logic [7:0] cur_code;
    logic hold;
    logic pending;
    logic best_any;
    logic [7:0] best_code;
    logic soft_do;
    logic status_wr;
    logic clear_wr;
    logic test_wr;

    assign status_wr = ce_i && req_i.wr && hit(req_i, ADDR_INT_STATUS);
    assign clear_wr = status_wr && req_i.wdata == CLEAR_CODE;
    assign test_wr = ce_i && req_i.wr && hit(req_i, ADDR_TEST_CTRL);
    // Held off while the serial slave is mid-transfer
    assign soft_do = ce_i && pending && !transfer_active_i;

    source_priority_pick u_pick (
        .active_i(src_active_i),
        .any_o(best_any),
        .code_o(best_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status

    // One idle cycle after a clear lets the source logic drop the acked flag
    always_ff @(posedge clock_i) begin
        if (soft_reset_request_i || soft_do) begin
            cur_code <= STATUS_RESET;
            int_n_o <= 1'b1;
            hold <= 1'b0;
            clear_ack_o <= 1'b0;
            clear_code_o <= STATUS_RESET;
        end else if (ce_i) begin
            clear_ack_o <= 1'b0;
            if (clear_wr && !int_n_o) begin
                cur_code <= STATUS_RESET;
                int_n_o <= 1'b1;
                hold <= 1'b1;
                clear_ack_o <= 1'b1;
                clear_code_o <= cur_code;
            end else if (hold) begin
                hold <= 1'b0;
            end else if (int_n_o && best_any) begin
                cur_code <= best_code;
                int_n_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test register and soft reset

    // A new request landing on the firing edge is kept, not lost
    always_ff @(posedge clock_i) begin
        if (soft_reset_request_i) begin
            pending <= 1'b0;
        end else if (test_wr && req_i.wdata[BIT_SOFT_RESET]) begin
            pending <= 1'b1;
        end else if (soft_do) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (soft_reset_request_i) begin
            soft_reset_o <= 1'b0;
        end else if (ce_i) begin
            soft_reset_o <= soft_do;
        end
    end

    always_ff @(posedge clock_i) begin
        if (soft_reset_request_i || soft_do) begin
            bypass_o <= '0;
        end else if (test_wr) begin
            bypass_o.fan_divider_bypass <= req_i.wdata[BIT_FAN_BYPASS];
            bypass_o.flash_divider_bypass <= req_i.wdata[BIT_FLASH_BYPASS];
            bypass_o.serial_filter_bypass <= req_i.wdata[BIT_FILTER_BYPASS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, one cycle latency; other addresses read zero and no hit

    always_ff @(posedge clock_i) begin
        if (soft_reset_request_i) begin
            rd_data_o <= 8'h00;
            rd_hit_o <= 1'b0;
        end else if (ce_i) begin
            rd_data_o <= 8'h00;
            rd_hit_o <= 1'b0;
            if (req_i.rd && hit(req_i, ADDR_INT_STATUS)) begin
                rd_data_o <= cur_code;
                rd_hit_o <= 1'b1;
            end else if (req_i.rd && hit(req_i, ADDR_TEST_CTRL)) begin
                rd_data_o <= {pending, 4'h0, bypass_o.fan_divider_bypass,
                              bypass_o.flash_divider_bypass, bypass_o.serial_filter_bypass};
                rd_hit_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Kept apart from the picker so that a picker fault is caught
    function automatic logic any_below(input logic [NUM_SRC-1:0] act, input logic [7:0] code);
        logic found;
        found = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (act[i] && SRC_CODE[i] < code) begin
                found = 1'b1;
            end
        end
        return found;
    endfunction

    property p_latch_lowest;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (ce_i && !soft_do && int_n_o && !hold && (|src_active_i) && !clear_wr)
            |=> (!int_n_o && cur_code != STATUS_RESET && !any_below($past(src_active_i), cur_code));
    endproperty
    a_latch_lowest: assert property (p_latch_lowest) else $error("lowest source not latched");

    property p_clear;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (clear_wr && !int_n_o && !soft_do) |=> (int_n_o && clear_ack_o && cur_code == STATUS_RESET);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not release interrupt");

    property p_rearm;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (clear_wr && !int_n_o && !soft_do) ##1 (ce_i && !soft_do) ##1 (ce_i && !soft_do && best_any)
            |=> (!int_n_o && cur_code != STATUS_RESET);
    endproperty
    a_rearm: assert property (p_rearm) else $error("remaining source not re-raised");

    property p_other_write;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (status_wr && !clear_wr && !int_n_o && !soft_do) |=> ($stable(cur_code) && !int_n_o);
    endproperty
    a_other_write: assert property (p_other_write) else $error("non-clear write changed status");

    property p_soft_wait;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (pending && transfer_active_i) |=> !soft_reset_o;
    endproperty
    a_soft_wait: assert property (p_soft_wait) else $error("soft reset during transfer");

    property p_soft_do;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (soft_do && !(test_wr && req_i.wdata[BIT_SOFT_RESET]))
            |=> (soft_reset_o && int_n_o && bypass_o == '0 && !pending ##1 !soft_reset_o);
    endproperty
    a_soft_do: assert property (p_soft_do) else $error("soft reset incomplete");

    property p_zero_write;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (test_wr && !req_i.wdata[BIT_SOFT_RESET] && !pending) |=> (!pending ##1 !soft_reset_o);
    endproperty
    a_zero_write: assert property (p_zero_write) else $error("zero write started reset");

    property p_bypass_write;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (test_wr && !soft_do) |=> (bypass_o.fan_divider_bypass == $past(req_i.wdata[BIT_FAN_BYPASS])
            && bypass_o.flash_divider_bypass == $past(req_i.wdata[BIT_FLASH_BYPASS])
            && bypass_o.serial_filter_bypass == $past(req_i.wdata[BIT_FILTER_BYPASS]));
    endproperty
    a_bypass_write: assert property (p_bypass_write) else $error("bypass bits not stored");

    property p_reset_clear;
        @(posedge clock_i)
        soft_reset_request_i |=> (bypass_o == '0 && int_n_o && !pending);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("bypass not cleared by reset");

    property p_read_status;
        @(posedge clock_i) disable iff (soft_reset_request_i)
        (ce_i && req_i.rd && hit(req_i, ADDR_INT_STATUS)) |=> (rd_hit_o && rd_data_o == $past(cur_code));
    endproperty
    a_read_status: assert property (p_read_status) else $error("status readback wrong");

endmodule

// *** rtl/isr_test_pkg.sv ***
// Package: register map, field positions, source codes and bus carrier
package isr_test_pkg;

    localparam logic [7:0] ADDR_INT_STATUS = 8'hF8;
    localparam logic [7:0] ADDR_TEST_CTRL = 8'hFC;

    localparam logic [7:0] CLEAR_CODE = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    localparam int BIT_SOFT_RESET = 7;
    localparam int BIT_FAN_BYPASS = 2;
    localparam int BIT_FLASH_BYPASS = 1;
    localparam int BIT_FILTER_BYPASS = 0;

    localparam int NUM_SRC = 8;

    // Addresses of the enabling registers that own each source line
    localparam logic [7:0] SRC_CODE [NUM_SRC] = '{
        8'h10, 8'h11, 8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41
    };

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic fan_divider_bypass;
        logic flash_divider_bypass;
        logic serial_filter_bypass;
    } bypass_t;

endpackage

// *** rtl/source_priority_pick.sv ***
// Picks the active interrupt source with the lowest address code
`timescale 1ns/1ns
module source_priority_pick
    import isr_test_pkg::*;
(
    input wire logic [NUM_SRC-1:0] active_i,
    output logic any_o,
    output logic [7:0] code_o
);

    always_comb begin
        any_o = 1'b0;
        code_o = STATUS_RESET;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (active_i[i] && (!any_o || SRC_CODE[i] < code_o)) begin
                any_o = 1'b1;
                code_o = SRC_CODE[i];
            end
        end
    end

endmodule
